// ---- core/csfa_top.sv ----
// Command front end: round-robin queue arbitration with burst limit,
// atomic fused-pair execution and completion status encoding.
// Assumes fetched entries are offered per queue with valid/ready and that
// an execution engine reports the error causes for the command it ran.
`default_nettype none
module csfa_top
	import csfa_pkg::*;
#(
	parameter int NQ = 4,
	parameter int BW = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic [BW-1:0] i_burst,
	input wire logic [NQ-1:0] i_sq_valid,
	input wire csfa_cmd_s [NQ-1:0] i_sq_cmd,
	output logic [NQ-1:0] o_sq_ready,
	output logic o_exec_valid,
	output csfa_cmd_s o_exec_cmd,
	output logic [15:0] o_exec_sqid,
	input wire logic i_exec_done,
	input wire logic [NERR-1:0] i_exec_err,
	input wire logic i_exec_miscompare,
	input wire logic i_exec_denied,
	output logic o_cpl_valid,
	output csfa_cpl_s o_cpl,
	input wire logic i_cpl_ready,
	output logic [1:0] o_arbitration_scheme_support_field,
	output logic [$clog2(NQ)-1:0] o_rr_ptr
);
	localparam int QW = $clog2(NQ);

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_EXEC = 5'b00010,
		ST_CPL = 5'b00100,
		ST_ABORT2 = 5'b01000,
		ST_ARB = 5'b10000
	} csfa_st_e;

	csfa_st_e st_r, st_nxt;
	logic [QW-1:0] ptr_r;
	logic [BW-1:0] used_r;
	logic fused_r, second_r, fail1_r;
	csfa_cmd_s first_r;
	csfa_cpl_s cpl_r;

	// Lowest set error index gives the lowest numeric code within a type.
	// The result packs the status type above the status code, so that the
	// function has inputs only and may feed a continuous assignment.
	function automatic logic [10:0] pick_code(input logic [NERR-1:0] e,
		input logic mc, input logic dn);
		logic [10:0] r;
		r = {SCT_GENERIC, SC_SUCCESS};
		if (e[E_CQ_INVALID]) r = {SCT_CMD_SPEC, SC_CQ_INVALID};
		else if (e[E_BAD_QID]) r = {SCT_CMD_SPEC, SC_BAD_QID};
		else if (e[E_MAX_QSIZE]) r = {SCT_CMD_SPEC, SC_MAX_QSIZE};
		else if (e[E_ABORT_LIMIT]) r = {SCT_CMD_SPEC, SC_ABORT_LIMIT};
		else if (e[E_AER_LIMIT]) r = {SCT_CMD_SPEC, SC_AER_LIMIT};
		else if (e[E_FW_SLOT]) r = {SCT_CMD_SPEC, SC_FW_SLOT};
		else if (e[E_FW_IMAGE]) r = {SCT_CMD_SPEC, SC_FW_IMAGE};
		else if (e[E_INT_VECTOR]) r = {SCT_CMD_SPEC, SC_INT_VECTOR};
		else if (e[E_LOG_PAGE]) r = {SCT_CMD_SPEC, SC_LOG_PAGE};
		else if (e[E_FORMAT]) r = {SCT_CMD_SPEC, SC_FORMAT};
		else if (e[E_FW_RESET]) r = {SCT_CMD_SPEC, SC_FW_RESET};
		else if (e[E_Q_DELETE]) r = {SCT_CMD_SPEC, SC_Q_DELETE};
		else if (e[E_CONFLICT_ATTR]) r = {SCT_CMD_SPEC, SC_CONFLICT_ATTR};
		else if (e[E_BAD_PROT]) r = {SCT_CMD_SPEC, SC_BAD_PROT};
		else if (e[E_RO_WRITE]) r = {SCT_CMD_SPEC, SC_RO_WRITE};
		else if (e[E_WRITE_FAULT]) r = {SCT_MEDIA, SC_WRITE_FAULT};
		else if (e[E_READ_UNREC]) r = {SCT_MEDIA, SC_READ_UNREC};
		else if (e[E_GUARD]) r = {SCT_MEDIA, SC_GUARD};
		else if (e[E_APP_TAG]) r = {SCT_MEDIA, SC_APP_TAG};
		else if (e[E_REF_TAG]) r = {SCT_MEDIA, SC_REF_TAG};
		else if (mc) r = {SCT_MEDIA, SC_MISCOMPARE};
		else if (dn) r = {SCT_MEDIA, SC_ACCESS_DENIED};
		return r;
	endfunction

	wire [1:0] fuse_f = i_sq_cmd[ptr_r].dw0[FUSE_LSB+:2];
	wire head_valid = i_sq_valid[ptr_r];
	wire is_first = head_valid && (fuse_f == FUSE_FIRST);
	wire burst_done = (used_r + BW'(1) >= i_burst) || (i_burst == '0);
	wire [QW-1:0] ptr_inc = QW'((ptr_r + 1'b1) % NQ);
	wire range_bad = (first_r.uses_range || i_sq_cmd[ptr_r].uses_range) &&
		((first_r.lba_start != i_sq_cmd[ptr_r].lba_start) ||
		(first_r.lba_count != i_sq_cmd[ptr_r].lba_count));
	wire [10:0] stat_w = pick_code(i_exec_err, i_exec_miscompare,
		i_exec_denied);
	wire [2:0] sct_w = stat_w[10:8];
	wire [7:0] sc_w = stat_w[7:0];
	wire take = (st_r == ST_IDLE) && head_valid && i_ce;
	// The second entry of a pair is consumed when it is aborted as well,
	// so it cannot turn up again later as a fresh command.
	wire take2 = ((st_r == ST_ARB) || (st_r == ST_ABORT2)) && i_ce &&
		head_valid;

	// Fused second entry is consumed only right after the first: no other
	// queue may be served in between, which keeps the pair atomic.
	always_comb begin
		o_sq_ready = '0;
		if (take || take2) begin
			o_sq_ready[ptr_r] = 1'b1;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: if (head_valid) st_nxt = ST_EXEC;
			ST_EXEC: if (i_exec_done) st_nxt = ST_CPL;
			ST_CPL: begin
				if (i_cpl_ready) begin
					if (fused_r && !second_r && fail1_r) st_nxt = ST_ABORT2;
					else if (fused_r && !second_r) st_nxt = ST_ARB;
					else st_nxt = ST_IDLE;
				end
			end
			ST_ABORT2: if (head_valid) st_nxt = ST_CPL;
			ST_ARB: if (head_valid) st_nxt = range_bad ? ST_CPL : ST_EXEC;
			default: st_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r <= ST_IDLE;
			ptr_r <= '0;
			used_r <= '0;
			fused_r <= 1'b0;
			second_r <= 1'b0;
			fail1_r <= 1'b0;
			first_r <= '0;
			cpl_r <= '0;
			o_exec_valid <= 1'b0;
			o_exec_cmd <= '0;
			o_exec_sqid <= '0;
		end else if (i_ce) begin
			st_r <= st_nxt;
			o_exec_valid <= 1'b0;
			if (st_r == ST_IDLE && !head_valid) begin
				ptr_r <= ptr_inc;
				used_r <= '0;
			end
			if (take) begin
				fused_r <= is_first;
				second_r <= 1'b0;
				fail1_r <= 1'b0;
				first_r <= i_sq_cmd[ptr_r];
				o_exec_valid <= 1'b1;
				o_exec_cmd <= i_sq_cmd[ptr_r];
				o_exec_sqid <= 16'(ptr_r);
				cpl_r.cid <= i_sq_cmd[ptr_r].dw0[31:16];
				cpl_r.sqid <= 16'(ptr_r);
			end
			if (st_r == ST_EXEC && i_exec_done) begin
				cpl_r.sct <= sct_w;
				cpl_r.sc <= sc_w;
				fail1_r <= (sc_w != SC_SUCCESS) || (sct_w != SCT_GENERIC);
			end
			if (st_r == ST_ARB && head_valid) begin
				// Only the second half of a bad-range pair reports invalid field.
				second_r <= 1'b1;
				cpl_r.cid <= i_sq_cmd[ptr_r].dw0[31:16];
				cpl_r.sct <= SCT_GENERIC;
				cpl_r.sc <= range_bad ? SC_INVALID_FIELD : SC_SUCCESS;
				o_exec_valid <= !range_bad;
				o_exec_cmd <= i_sq_cmd[ptr_r];
			end
			if (st_r == ST_ABORT2 && head_valid) begin
				second_r <= 1'b1;
				cpl_r.cid <= i_sq_cmd[ptr_r].dw0[31:16];
				cpl_r.sct <= SCT_GENERIC;
				cpl_r.sc <= SC_ABORT_FUSED_FAIL;
			end
			if (st_r == ST_CPL && i_cpl_ready && st_nxt == ST_IDLE) begin
				// A fused pair counts as one command against the burst.
				if (burst_done) begin
					ptr_r <= ptr_inc;
					used_r <= '0;
				end else begin
					used_r <= used_r + BW'(1);
				end
			end
		end
	end

	// An executed command's completion only appears after execution is done, so
	// any state the command changed is already settled. The entry comes straight
	// from its register, so it is valid in the same cycle as o_cpl_valid.
	assign o_cpl_valid = (st_r == ST_CPL);
	assign o_cpl = cpl_r;

	// The second entry of a pair is only visible once the first has run, so
	// the first half of a mismatched pair keeps its own status and only the
	// second half reports invalid field.
	assign o_arbitration_scheme_support_field = ARB_SUPPORT;
	assign o_rr_ptr = ptr_r;
endmodule
`default_nettype wire

// ---- core/csfa_pkg.sv ----
// Package for the command front end: status codes, fused-field encodings,
// arbitration scheme codes and the structs that carry commands and results.
// Assumes a single clock domain and synchronous inputs.
`default_nettype none
package csfa_pkg;
	// Status code types.
	localparam logic [2:0] SCT_GENERIC = 3'h0;
	localparam logic [2:0] SCT_CMD_SPEC = 3'h1;
	localparam logic [2:0] SCT_MEDIA = 3'h2;
	// Generic status values.
	localparam logic [7:0] SC_SUCCESS = 8'h00;
	localparam logic [7:0] SC_INVALID_FIELD = 8'h02;
	localparam logic [7:0] SC_ABORT_FUSED_FAIL = 8'h09;
	// Command specific values, admin range.
	localparam logic [7:0] SC_CQ_INVALID = 8'h00;
	localparam logic [7:0] SC_BAD_QID = 8'h01;
	localparam logic [7:0] SC_MAX_QSIZE = 8'h02;
	localparam logic [7:0] SC_ABORT_LIMIT = 8'h03;
	localparam logic [7:0] SC_AER_LIMIT = 8'h05;
	localparam logic [7:0] SC_FW_SLOT = 8'h06;
	localparam logic [7:0] SC_FW_IMAGE = 8'h07;
	localparam logic [7:0] SC_INT_VECTOR = 8'h08;
	localparam logic [7:0] SC_LOG_PAGE = 8'h09;
	localparam logic [7:0] SC_FORMAT = 8'h0A;
	localparam logic [7:0] SC_FW_RESET = 8'h0B;
	localparam logic [7:0] SC_Q_DELETE = 8'h0C;
	localparam logic [7:0] SC_ADMIN_MAX = 8'h7F;
	// Command specific values, block I/O range.
	localparam logic [7:0] SC_IO_MIN = 8'h80;
	localparam logic [7:0] SC_IO_MAX = 8'hBF;
	localparam logic [7:0] SC_CONFLICT_ATTR = 8'h80;
	localparam logic [7:0] SC_BAD_PROT = 8'h81;
	localparam logic [7:0] SC_RO_WRITE = 8'h82;
	// Media values.
	localparam logic [7:0] SC_WRITE_FAULT = 8'h80;
	localparam logic [7:0] SC_READ_UNREC = 8'h81;
	localparam logic [7:0] SC_GUARD = 8'h82;
	localparam logic [7:0] SC_APP_TAG = 8'h83;
	localparam logic [7:0] SC_REF_TAG = 8'h84;
	localparam logic [7:0] SC_MISCOMPARE = 8'h85;
	localparam logic [7:0] SC_ACCESS_DENIED = 8'h86;
	localparam logic [7:0] SC_VENDOR_MIN = 8'hC0;
	// Fused field of command dword 0.
	localparam logic [1:0] FUSE_NONE = 2'h0;
	localparam logic [1:0] FUSE_FIRST = 2'h1;
	localparam logic [1:0] FUSE_SECOND = 2'h2;
	localparam int FUSE_LSB = 8;
	// Arbitration scheme support bits: bit 0 weighted, bit 1 vendor.
	localparam logic [1:0] ARB_SUPPORT = 2'h0;
	// Error cause bits, one per status code; index order sets priority.
	localparam int NERR = 20;
	localparam int E_CQ_INVALID = 0;
	localparam int E_BAD_QID = 1;
	localparam int E_MAX_QSIZE = 2;
	localparam int E_ABORT_LIMIT = 3;
	localparam int E_AER_LIMIT = 4;
	localparam int E_FW_SLOT = 5;
	localparam int E_FW_IMAGE = 6;
	localparam int E_INT_VECTOR = 7;
	localparam int E_LOG_PAGE = 8;
	localparam int E_FORMAT = 9;
	localparam int E_FW_RESET = 10;
	localparam int E_Q_DELETE = 11;
	localparam int E_CONFLICT_ATTR = 12;
	localparam int E_BAD_PROT = 13;
	localparam int E_RO_WRITE = 14;
	localparam int E_WRITE_FAULT = 15;
	localparam int E_READ_UNREC = 16;
	localparam int E_GUARD = 17;
	localparam int E_APP_TAG = 18;
	localparam int E_REF_TAG = 19;
	localparam logic [7:0] SC_MEDIA_LAST_A = SC_REF_TAG;

	typedef struct packed {
		logic [31:0] dw0;
		logic [63:0] lba_start;
		logic [15:0] lba_count;
		logic uses_range;
	} csfa_cmd_s;

	typedef struct packed {
		logic [15:0] cid;
		logic [15:0] sqid;
		logic [2:0] sct;
		logic [7:0] sc;
	} csfa_cpl_s;
endpackage
`default_nettype wire

// ---- dv/csfa_top_props.sv ----
// Checker for the command front end, bound to every csfa_top instance.
// Sees only the top module's ports; one clock domain.
`default_nettype none
module csfa_top_props
	import csfa_pkg::*;
#(
	parameter int NQ = 4,
	parameter int BW = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	input wire logic [BW-1:0] i_burst,
	input wire logic [NQ-1:0] i_sq_valid,
	input wire csfa_cmd_s [NQ-1:0] i_sq_cmd,
	input wire logic [NQ-1:0] o_sq_ready,
	input wire logic o_exec_valid,
	input wire csfa_cmd_s o_exec_cmd,
	input wire logic [15:0] o_exec_sqid,
	input wire logic i_exec_done,
	input wire logic o_cpl_valid,
	input wire csfa_cpl_s o_cpl,
	input wire logic i_cpl_ready,
	input wire logic [1:0] o_arbitration_scheme_support_field,
	input wire logic [$clog2(NQ)-1:0] o_rr_ptr
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	logic [1:0] pop_fuse;
	logic [$clog2(NQ)-1:0] pop_q;
	logic [BW:0] run;
	wire pop = |o_sq_ready;
	wire [1:0] hfuse = i_sq_cmd[o_rr_ptr].dw0[9:8];
	wire others = |(i_sq_valid & ~o_sq_ready);
	wire [BW:0] lim = {1'b0, i_burst} + (BW+1)'(i_burst == '0);
	// Run length only grows while another queue was kept waiting.
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pop_fuse <= FUSE_NONE;
			pop_q <= '0;
			run <= '0;
		end else if (pop) begin
			pop_fuse <= hfuse;
			pop_q <= o_rr_ptr;
			if (hfuse != FUSE_SECOND)
				run <= (pop_q == o_rr_ptr && others) ? run + 1'b1 : (BW+1)'(1);
		end
	end
	sequence s_pop;
		pop;
	endsequence
	a_own_queue: assert property (
		s_pop |-> $onehot(o_sq_ready) && o_sq_ready[o_rr_ptr])
		else $error("ready given off the pointer");
	a_pop_submitted: assert property (
		(o_sq_ready & ~i_sq_valid) == '0) else $error("pop of empty queue");
	// An aborted or mismatched second half goes straight to completion.
	a_exec_head: assert property (
		s_pop |=> o_cpl_valid || (o_exec_valid
		&& o_exec_cmd == $past(i_sq_cmd[o_rr_ptr])
		&& o_exec_sqid == 16'($past(o_rr_ptr)))) else $error("bad issue");
	a_no_exec_cpl: assert property (
		o_cpl_valid |-> !o_exec_valid) else $error("aborted entry issued");
	a_cpl_stable: assert property (
		o_cpl_valid && !i_cpl_ready |=> $stable(o_cpl))
		else $error("completion changed while waiting");
	a_ce_freeze: assert property (
		!i_ce |=> $stable(o_rr_ptr)) else $error("pointer moved while frozen");
	a_done_cpl: assert property (
		i_exec_done |=> o_cpl_valid) else $error("no completion");
	a_cpl_holds: assert property (
		o_cpl_valid && !i_cpl_ready |=> o_cpl_valid) else $error("cpl dropped");
	a_no_overlap: assert property (
		o_cpl_valid |-> !pop) else $error("pop during completion");
	a_fused_next: assert property (
		s_pop ##0 pop_fuse == FUSE_FIRST |-> o_rr_ptr == pop_q
		&& hfuse == FUSE_SECOND) else $error("fused pair split");
	a_burst_cap: assert property (
		run <= lim) else $error("burst exceeded");
	a_scheme_field: assert property (
		o_arbitration_scheme_support_field == ARB_SUPPORT)
		else $error("scheme field");
endmodule
bind csfa_top csfa_top_props #(.NQ(NQ), .BW(BW)) u_csfa_top_props (
	.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_ce(i_ce),
	.i_burst(i_burst), .o_cpl(o_cpl),
	.i_sq_valid(i_sq_valid), .i_sq_cmd(i_sq_cmd), .o_sq_ready(o_sq_ready),
	.o_exec_valid(o_exec_valid), .o_exec_cmd(o_exec_cmd),
	.o_exec_sqid(o_exec_sqid), .i_exec_done(i_exec_done),
	.o_cpl_valid(o_cpl_valid), .i_cpl_ready(i_cpl_ready),
	.o_arbitration_scheme_support_field(o_arbitration_scheme_support_field),
	.o_rr_ptr(o_rr_ptr));
`default_nettype wire

// ---- dv/csfa_host_model.sv ----
// Host queues of eight entries each, plus an engine whose latency and
// error causes are keyed by the command id. Assumes one clock.
`default_nettype none
module csfa_host_model
	import csfa_pkg::*;
#(
	parameter int NQ = 4
) (
	input wire logic i_ref_clk,
	input wire logic [NQ-1:0] i_sq_ready,
	input wire logic i_exec_valid,
	input wire csfa_cmd_s i_exec_cmd,
	output logic [NQ-1:0] o_sq_valid,
	output csfa_cmd_s [NQ-1:0] o_sq_cmd,
	output logic o_done,
	output logic [NERR+1:0] o_err
);
	csfa_cmd_s ring [NQ][8] = '{default: '0};
	int hd [NQ];
	int tl [NQ];
	logic [NERR+1:0] err_tab [256] = '{default: '0};
	int wt = 0;
	logic [7:0] tag;
	// One call is one doorbell, so a fused pair shows up in one step.
	task push(input int q, input int cid, input int n, input logic fz,
		input logic [15:0] cnt2);
		for (int k = 0; k < n; k++)
			ring[q][(tl[q] + k) % 8] = '{{16'(cid + k), 6'h00,
				fz ? 2'(k + 1) : FUSE_NONE, 8'h01}, 64'h1000,
				(fz && k == 1) ? cnt2 : 16'h0008, 1'b1};
		tl[q] <= tl[q] + n;
	endtask
	for (genvar g = 0; g < NQ; g++) begin : g_q
		// An empty queue shows the inverse of its head slot, not a stale copy.
		always_comb begin
			o_sq_valid[g] = hd[g] != tl[g];
			o_sq_cmd[g] = o_sq_valid[g] ? ring[g][hd[g] % 8] : ~ring[g][hd[g] % 8];
		end
		always @(posedge i_ref_clk) begin
			if (i_sq_ready[g])
				hd[g] <= hd[g] + 1;
		end
	end
	initial begin
		o_done = 1'b0;
		o_err = '0;
	end
	always @(posedge i_ref_clk) begin
		o_done <= wt == 1;
		o_err <= (wt == 1) ? err_tab[tag] : ~o_err;
		if (i_exec_valid) begin
			wt <= int'(i_exec_cmd.dw0[18:16]) + 1;
			tag <= i_exec_cmd.dw0[23:16];
		end else if (wt > 0)
			wt <= wt - 1;
	end
endmodule
`default_nettype wire

// ---- dv/csfa_top_bench.sv ----
// Self-checking bench for csfa_top: the host model fills the queues and
// plays the engine; completions are logged and compared in order.
`default_nettype none
module csfa_top_bench
	import csfa_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic rdy = 1'b1;
	logic [7:0] burst = 8'h01;
	logic [3:0] sqv, sqr;
	csfa_cmd_s [3:0] sqc;
	csfa_cmd_s xcmd;
	logic xv, done, cv;
	logic [NERR+1:0] err;
	logic [15:0] xsq;
	logic [1:0] ptr, arb;
	csfa_cpl_s cpl;
	csfa_cpl_s cq [$];
	logic [15:0] sl [$];
	logic [7:0] code [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06,
		8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h80, 8'h81, 8'h82, 8'h80,
		8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h02, 8'h80};
	int fails = 0;
	int n_checks = 0;
	int p;
	always #4 clk = ~clk;
	csfa_top #(.NQ(4), .BW(8)) u_csfa_top (.i_ref_clk(clk), .i_arst_n(rst_n),
		.i_ce(ce), .i_burst(burst), .i_sq_valid(sqv), .i_sq_cmd(sqc),
		.o_sq_ready(sqr), .o_exec_valid(xv), .o_exec_cmd(xcmd),
		.o_exec_sqid(xsq), .i_exec_done(done), .i_exec_err(err[NERR-1:0]),
		.i_exec_miscompare(err[NERR]), .i_exec_denied(err[NERR+1]),
		.o_cpl_valid(cv), .o_cpl(cpl), .i_cpl_ready(rdy),
		.o_arbitration_scheme_support_field(arb), .o_rr_ptr(ptr));
	csfa_host_model #(.NQ(4)) u_csfa_host_model (.i_ref_clk(clk),
		.i_sq_ready(sqr), .i_exec_valid(xv), .i_exec_cmd(xcmd),
		.o_sq_valid(sqv), .o_sq_cmd(sqc), .o_done(done), .o_err(err));
	// Ready toggles every cycle so a completion that arrives while it is low meets a stall.
	always @(posedge clk) begin
		rdy <= ~rdy;
		// The entry is taken at the very edge on which it is accepted.
		if (cv && rdy)
			cq.push_back(cpl);
		if (xv)
			sl.push_back(xsq);
	end
	task automatic chk(input logic [42:0] got, input logic [42:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic ecpl(input int q, input int c, input logic [2:0] t,
		input logic [7:0] s);
		csfa_cpl_s x;
		x = cq.pop_front();
		chk({x.sqid, x.cid, x.sct, x.sc}, {16'(q), 16'(c), t, s});
	endtask
	task automatic wait_cpl(input int n);
		for (int t = 0; t < 2000 && cq.size() < n; t++)
			@(posedge clk);
		if (cq.size() < n) begin
			fails++;
			$display("unexpected at %0t: completion missing", $time);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d, failures %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200us;
		fails++;
		$display("unexpected at %0t: watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 24; i++) begin
			u_csfa_host_model.err_tab[i + 1] = (i == 22) ? 22'h020084 :
				(i == 23) ? 22'h108000 : 22'(1) << i;
			u_csfa_host_model.push(i % 4, i + 1, 1, 1'b0, 16'h0008);
			wait_cpl(1);
			ecpl(i % 4, i + 1, (i < 15 || i == 22) ? SCT_CMD_SPEC : SCT_MEDIA,
				code[i]);
		end
		u_csfa_host_model.push(1, 40, 1, 1'b0, 16'h0008);
		u_csfa_host_model.push(0, 41, 2, 1'b1, 16'h0008);
		u_csfa_host_model.push(2, 43, 1, 1'b0, 16'h0008);
		wait_cpl(4);
		p = 0;
		foreach (cq[k])
			if (cq[k].cid === 16'h0029)
				p = k;
		chk(43'(cq[p + 1].cid), 43'h2A);
		foreach (cq[k])
			chk(43'({cq[k].sct, cq[k].sc}), 43'h0);
		cq.delete();
		u_csfa_host_model.err_tab[50] = 22'h020000;
		u_csfa_host_model.push(1, 50, 2, 1'b1, 16'h0008);
		wait_cpl(2);
		ecpl(1, 50, SCT_MEDIA, 8'h82);
		ecpl(1, 51, SCT_GENERIC, 8'h09);
		u_csfa_host_model.push(3, 60, 2, 1'b1, 16'h0010);
		wait_cpl(2);
		ecpl(3, 60, SCT_GENERIC, 8'h00);
		ecpl(3, 61, SCT_GENERIC, 8'h02);
		// Two plain entries in one push: each completes with success on its own.
		u_csfa_host_model.push(3, 90, 2, 1'b0, 16'h0008);
		wait_cpl(2);
		ecpl(3, 90, SCT_GENERIC, 8'h00);
		ecpl(3, 91, SCT_GENERIC, 8'h00);
		burst <= 8'h02;
		sl.delete();
		u_csfa_host_model.push(0, 70, 4, 1'b0, 16'h0008);
		u_csfa_host_model.push(2, 80, 4, 1'b0, 16'h0008);
		wait_cpl(8);
		for (int k = 0; k < 8; k += 2) begin
			chk(43'(sl[k]), 43'(sl[k + 1]));
			chk(43'(sl[k] == sl[(k + 2) % 8]), 43'h0);
		end
		// With the queues empty the pointer would step every cycle.
		ce <= 1'b0;
		@(posedge clk);
		p = int'(ptr);
		repeat (4) @(posedge clk);
		chk(43'(ptr), 43'(p));
		ce <= 1'b1;
		repeat (2) @(posedge clk);
		chk(43'(ptr), 43'((p + 1) % 4));
		chk(43'(arb), 43'(ARB_SUPPORT));
		stop_test();
	end
endmodule
`default_nettype wire
